// file: rtl/cams_dev.sv
// Purpose: 32-word by 32-bit content search memory with per-bit masking
// Assumes: Host holds each request until it is taken
// Notes:   Results are registered; one search in flight at a time
`timescale 1ns/1ps
`default_nettype none

module cams_dev #(
  parameter int WORDS = cams_pkg::WORDS,
  parameter int DATA_W = cams_pkg::DATA_W,
  parameter logic [cams_pkg::WORDS*cams_pkg::DATA_W-1:0] INIT_DATA = '0,
  parameter logic [cams_pkg::WORDS*cams_pkg::DATA_W-1:0] INIT_CARE = '1
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Link to user logic
  cams_if.dev bus
);
  // ==========================================================
  // Elaboration checks
  // ==========================================================
  // Refuse a geometry that two result lanes cannot cover
  if (WORDS != cams_pkg::WORDS || WORDS != 2 * cams_pkg::LANE_W) begin : g_bad_words
    $error("cams_dev: word count must fill two result lanes");
  end
  // Stored width is fixed by the link
  if (DATA_W != cams_pkg::DATA_W) begin : g_bad_width
    $error("cams_dev: word width must match the package");
  end

  // ==========================================================
  // Helper functions
  // ==========================================================
  // Compare a key with one stored word, cleared care bits ignored
  function automatic logic word_hit(input logic [DATA_W-1:0] key,
                                    input logic [DATA_W-1:0] stored,
                                    input logic [DATA_W-1:0] care);
    word_hit = (((key ^ stored) & care) == '0);
  endfunction

  // Lowest matching index
  function automatic logic [cams_pkg::ADDR_W-1:0] first_hit(input logic [WORDS-1:0] vec);
    logic [cams_pkg::ADDR_W-1:0] idx;
    idx = cams_pkg::ADDR_RESET;
    for (int i = WORDS - 1; i >= 0; i--) begin
      if (vec[i]) begin
        idx = cams_pkg::ADDR_W'(i);
      end
    end
    first_hit = idx;
  endfunction

  // More than one bit set
  function automatic logic several(input logic [WORDS-1:0] vec);
    several = ((vec & (vec - 1'b1)) != '0);
  endfunction

  // ==========================================================
  // Storage
  // ==========================================================
  logic [DATA_W-1:0] mem_data_reg [WORDS];
  logic [DATA_W-1:0] mem_care_reg [WORDS];
  cams_pkg::cams_wr_state_type wr_state_reg;
  cams_pkg::cams_wr_state_type wr_state_next;
  logic [cams_pkg::ADDR_W-1:0] wr_addr_reg;
  logic [DATA_W-1:0] wr_data_reg;
  logic [DATA_W-1:0] wr_care_reg;
  logic wr_take;
  logic wr_commit;
  logic [WORDS-1:0] hit_vec;
  logic srch_take;
  logic hold_high_reg;
  logic [cams_pkg::LANE_W-1:0] high_vec_reg;
  logic res_valid_reg;
  logic res_half_reg;
  logic res_found_reg;
  logic res_multi_reg;
  logic [cams_pkg::ADDR_W-1:0] res_addr_reg;
  logic [cams_pkg::LANE_W-1:0] res_vec_reg;

  // ==========================================================
  // Write sequencing
  // ==========================================================
  // Handshake terms
  assign bus.wr_ready = (wr_state_reg == cams_pkg::CAMS_WR_IDLE);
  assign wr_take = bus.wr_valid && bus.wr_ready;
  assign wr_commit = (wr_state_reg == cams_pkg::CAMS_WR_CYC3) ||
                     ((wr_state_reg == cams_pkg::CAMS_WR_CYC2) && (wr_care_reg == '1));

  // Next write state
  always_comb begin
    wr_state_next = wr_state_reg;
    case (wr_state_reg)
      cams_pkg::CAMS_WR_IDLE: begin
        if (wr_take) begin
          wr_state_next = cams_pkg::CAMS_WR_CYC2;
        end
      end
      cams_pkg::CAMS_WR_CYC2: begin
        if (wr_care_reg != '1) begin
          wr_state_next = cams_pkg::CAMS_WR_CYC3;
        end else begin
          wr_state_next = cams_pkg::CAMS_WR_IDLE;
        end
      end
      cams_pkg::CAMS_WR_CYC3: begin
        wr_state_next = cams_pkg::CAMS_WR_IDLE;
      end
      default: begin
        wr_state_next = cams_pkg::CAMS_WR_IDLE;
      end
    endcase
  end

  // Write state register
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_state_reg <= cams_pkg::CAMS_WR_IDLE;
    end else begin
      wr_state_reg <= wr_state_next;
    end
  end

  // Latch the taken write
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_addr_reg <= cams_pkg::ADDR_RESET;
      wr_data_reg <= cams_pkg::DATA_RESET;
      wr_care_reg <= cams_pkg::CARE_ALL;
    end else if (wr_take) begin
      wr_addr_reg <= bus.wr_addr;
      wr_data_reg <= bus.wr_data;
      wr_care_reg <= ~bus.wr_dont_care;
    end
  end

  // Word store, preloaded from configuration contents
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = 0; i < WORDS; i++) begin
        mem_data_reg[i] <= INIT_DATA[i*DATA_W +: DATA_W];
        mem_care_reg[i] <= INIT_CARE[i*DATA_W +: DATA_W];
      end
    end else if (wr_commit) begin
      mem_data_reg[wr_addr_reg] <= wr_data_reg;
      mem_care_reg[wr_addr_reg] <= wr_care_reg;
    end
  end

  // ==========================================================
  // Search
  // ==========================================================
  // Compare key with every word at once
  always_comb begin
    hit_vec = '0;
    for (int i = 0; i < WORDS; i++) begin
      hit_vec[i] = word_hit(bus.srch_key, mem_data_reg[i], mem_care_reg[i]);
    end
  end

  // Busy while the upper half is still to be shown
  assign bus.srch_ready = !hold_high_reg;
  assign srch_take = bus.srch_valid && bus.srch_ready;

  // Result registers
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hold_high_reg <= 1'b0;
      high_vec_reg <= cams_pkg::LANE_RESET;
      res_valid_reg <= 1'b0;
      res_half_reg <= cams_pkg::HALF_LOW;
      res_found_reg <= 1'b0;
      res_multi_reg <= 1'b0;
      res_addr_reg <= cams_pkg::ADDR_RESET;
      res_vec_reg <= cams_pkg::LANE_RESET;
    end else if (hold_high_reg) begin
      hold_high_reg <= 1'b0;
      res_valid_reg <= 1'b1;
      res_half_reg <= cams_pkg::HALF_HIGH;
      res_vec_reg <= high_vec_reg;
    end else if (srch_take) begin
      res_valid_reg <= 1'b1;
      res_half_reg <= cams_pkg::HALF_LOW;
      res_found_reg <= (hit_vec != '0);
      res_multi_reg <= several(hit_vec);
      res_addr_reg <= first_hit(hit_vec);
      if (bus.srch_mode == cams_pkg::MODE_UNENCODED) begin
        hold_high_reg <= 1'b1;
        res_vec_reg <= hit_vec[cams_pkg::LANE_W-1:0];
        high_vec_reg <= hit_vec[WORDS-1:cams_pkg::LANE_W];
      end else begin
        res_vec_reg <= cams_pkg::LANE_RESET;
      end
    end else begin
      res_valid_reg <= 1'b0;
    end
  end

  // Result outputs
  assign bus.res_valid = res_valid_reg;
  assign bus.res_half = res_half_reg;
  assign bus.res_found = res_found_reg;
  assign bus.res_multi = res_multi_reg;
  assign bus.res_addr = res_addr_reg;
  assign bus.res_vec = res_vec_reg;
endmodule // cams_dev

`default_nettype wire

// file: shared/cams_pkg.sv
// Purpose: Shared constants and types for the content search memory block
// Assumes: One system clock, 10 MHz
// Notes:   Both ends and the interface take their widths from here
`default_nettype none

package cams_pkg;
  // ==========================================================
  // Geometry
  // ==========================================================
  localparam int WORDS = 32;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 5;
  localparam int LANE_W = 16;
  localparam int CLOCK_HZ = 10_000_000;
  localparam int CLOCK_PERIOD_NS = 1_000_000_000 / CLOCK_HZ;

  // ==========================================================
  // Output modes and result halves
  // ==========================================================
  localparam logic MODE_ENCODED = 1'h0;
  localparam logic MODE_UNENCODED = 1'h1;
  localparam logic HALF_LOW = 1'h0;
  localparam logic HALF_HIGH = 1'h1;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] CARE_ALL = 32'hffff_ffff;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 5'h00;
  localparam logic [LANE_W-1:0] LANE_RESET = 16'h0000;

  // ==========================================================
  // State machines
  // ==========================================================
  typedef enum logic [2:0] {
    CAMS_WR_IDLE = 3'h1,
    CAMS_WR_CYC2 = 3'h2,
    CAMS_WR_CYC3 = 3'h4
  } cams_wr_state_type;

  typedef enum logic [3:0] {
    CAMS_HS_IDLE = 4'h1,
    CAMS_HS_REQ = 4'h2,
    CAMS_HS_WAIT = 4'h4,
    CAMS_HS_HIGH = 4'h8
  } cams_hs_state_type;
endpackage

`default_nettype wire

// file: shared/cams_if.sv
// Purpose: Link between the searching user logic and the search memory
// Assumes: Single clock shared by both ends
// Notes:   Valid/ready on writes and searches, result pulses back
`timescale 1ns/1ps
`default_nettype none

interface cams_if;
  // ==========================================================
  // Write channel
  // ==========================================================
  logic wr_valid;
  logic wr_ready;
  logic [cams_pkg::ADDR_W-1:0] wr_addr;
  logic [cams_pkg::DATA_W-1:0] wr_data;
  logic [cams_pkg::DATA_W-1:0] wr_dont_care;

  // ==========================================================
  // Search channel and result
  // ==========================================================
  logic srch_valid;
  logic srch_ready;
  logic srch_mode;
  logic [cams_pkg::DATA_W-1:0] srch_key;
  logic res_valid;
  logic res_half;
  logic res_found;
  logic res_multi;
  logic [cams_pkg::ADDR_W-1:0] res_addr;
  logic [cams_pkg::LANE_W-1:0] res_vec;

  // Memory end
  modport dev (
    input wr_valid, wr_addr, wr_data, wr_dont_care, srch_valid, srch_mode, srch_key,
    output wr_ready, srch_ready, res_valid, res_half, res_found, res_multi, res_addr,
    output res_vec
  );

  // User logic end
  modport host (
    output wr_valid, wr_addr, wr_data, wr_dont_care, srch_valid, srch_mode, srch_key,
    input wr_ready, srch_ready, res_valid, res_half, res_found, res_multi, res_addr,
    input res_vec
  );
endinterface

`default_nettype wire

// file: rtl/cams_host.sv
// Purpose: User-side end that issues writes and searches to the memory
// Assumes: One write and one search outstanding at a time
// Notes:   Gathers the two unencoded halves into one 32-bit vector
`timescale 1ns/1ps
`default_nettype none

module cams_host (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Write requests
  input wire logic i_wr_go,
  input wire logic [cams_pkg::ADDR_W-1:0] i_wr_addr,
  input wire logic [cams_pkg::DATA_W-1:0] i_wr_data,
  input wire logic [cams_pkg::DATA_W-1:0] i_wr_dont_care,
  output logic o_wr_busy,
  // Search requests and results
  input wire logic i_srch_go,
  input wire logic i_srch_mode,
  input wire logic [cams_pkg::DATA_W-1:0] i_srch_key,
  output logic o_srch_busy,
  output logic o_done,
  output logic o_found,
  output logic o_multi,
  output logic [cams_pkg::ADDR_W-1:0] o_match_addr,
  output logic [cams_pkg::WORDS-1:0] o_match_vec,
  // Link to the memory
  cams_if.host bus
);
  // ==========================================================
  // State
  // ==========================================================
  logic wr_pend_reg;
  cams_pkg::cams_hs_state_type hs_state_reg;
  logic mode_reg;

  // ==========================================================
  // Write side
  // ==========================================================
  // Hold the write on the link until taken
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_pend_reg <= 1'b0;
      bus.wr_addr <= cams_pkg::ADDR_RESET;
      bus.wr_data <= cams_pkg::DATA_RESET;
      bus.wr_dont_care <= cams_pkg::DATA_RESET;
    end else if (wr_pend_reg) begin
      if (bus.wr_ready) begin
        wr_pend_reg <= 1'b0;
      end
    end else if (i_wr_go) begin
      wr_pend_reg <= 1'b1;
      bus.wr_addr <= i_wr_addr;
      bus.wr_data <= i_wr_data;
      bus.wr_dont_care <= i_wr_dont_care;
    end
  end

  assign bus.wr_valid = wr_pend_reg;
  assign o_wr_busy = wr_pend_reg || !bus.wr_ready;

  // ==========================================================
  // Search side
  // ==========================================================
  // Request, wait, gather
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hs_state_reg <= cams_pkg::CAMS_HS_IDLE;
      mode_reg <= cams_pkg::MODE_ENCODED;
      bus.srch_key <= cams_pkg::DATA_RESET;
      o_done <= 1'b0;
      o_found <= 1'b0;
      o_multi <= 1'b0;
      o_match_addr <= cams_pkg::ADDR_RESET;
      o_match_vec <= '0;
    end else begin
      o_done <= 1'b0;
      case (hs_state_reg)
        cams_pkg::CAMS_HS_IDLE: begin
          if (i_srch_go) begin
            mode_reg <= i_srch_mode;
            bus.srch_key <= i_srch_key;
            hs_state_reg <= cams_pkg::CAMS_HS_REQ;
          end
        end
        cams_pkg::CAMS_HS_REQ: begin
          if (bus.srch_ready) begin
            hs_state_reg <= cams_pkg::CAMS_HS_WAIT;
          end
        end
        cams_pkg::CAMS_HS_WAIT: begin
          if (bus.res_valid) begin
            o_found <= bus.res_found;
            o_multi <= bus.res_multi;
            o_match_addr <= bus.res_addr;
            o_match_vec[cams_pkg::LANE_W-1:0] <= bus.res_vec;
            if (mode_reg == cams_pkg::MODE_UNENCODED) begin
              hs_state_reg <= cams_pkg::CAMS_HS_HIGH;
            end else begin
              o_done <= 1'b1;
              hs_state_reg <= cams_pkg::CAMS_HS_IDLE;
            end
          end
        end
        cams_pkg::CAMS_HS_HIGH: begin
          if (bus.res_valid && bus.res_half == cams_pkg::HALF_HIGH) begin
            o_match_vec[cams_pkg::WORDS-1:cams_pkg::LANE_W] <= bus.res_vec;
            o_done <= 1'b1;
            hs_state_reg <= cams_pkg::CAMS_HS_IDLE;
          end
        end
        default: begin
          hs_state_reg <= cams_pkg::CAMS_HS_IDLE;
        end
      endcase
    end
  end

  // Link drive
  assign bus.srch_valid = (hs_state_reg == cams_pkg::CAMS_HS_REQ);
  assign bus.srch_mode = mode_reg;
  assign o_srch_busy = (hs_state_reg != cams_pkg::CAMS_HS_IDLE);
endmodule // cams_host

`default_nettype wire

// file: tb/cams_sva.sv
// Purpose: Protocol checks on the link between user logic and search memory
// Assumes: Single clock, active-low asynchronous reset
// Notes:   Instantiated beside the link interface in the bench top
`timescale 1ns/1ps
`default_nettype none

module cams_sva (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Write channel
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire logic [cams_pkg::DATA_W-1:0] wr_dont_care,
  // Search channel and result
  input wire logic srch_valid,
  input wire logic srch_ready,
  input wire logic srch_mode,
  input wire logic res_valid,
  input wire logic res_half,
  input wire logic res_found,
  input wire logic res_multi,
  input wire logic [cams_pkg::ADDR_W-1:0] res_addr,
  input wire logic [cams_pkg::LANE_W-1:0] res_vec
);
  // ==========================================================
  // Sequences
  // ==========================================================
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  sequence s_wr_plain;
    !wr_ready ##1 wr_ready;
  endsequence
  sequence s_wr_mask;
    (!wr_ready)[*2] ##1 wr_ready;
  endsequence
  sequence s_two_halves;
    (res_valid && !res_half) ##1 (res_valid && res_half);
  endsequence

  // ==========================================================
  // Assertions
  // ==========================================================
  a_wr_plain_busy: assert property (
      wr_valid && wr_ready && wr_dont_care == 32'h0 |=> s_wr_plain)
    else $error("plain write not two cycles");
  a_wr_mask_busy: assert property (
      wr_valid && wr_ready && wr_dont_care != 32'h0 |=> s_wr_mask)
    else $error("masked write not three cycles");
  a_unenc_two_halves: assert property (
      srch_valid && srch_ready && srch_mode |=> s_two_halves)
    else $error("unencoded halves out of order");
  a_unenc_refuse_next: assert property (
      srch_valid && srch_ready && srch_mode |=> !srch_ready)
    else $error("search taken during upper half");
  a_enc_vec_zero: assert property (
      srch_valid && srch_ready && !srch_mode |=> res_valid && !res_half && res_vec == 16'h0000)
    else $error("encoded result malformed");
  a_res_has_cause: assert property (
      res_valid && !res_half |-> $past(srch_valid && srch_ready))
    else $error("result without search");
  a_none_addr_zero: assert property (
      res_valid && !res_half && !res_found |-> res_addr == 5'h00 && !res_multi)
    else $error("no match but address or multi set");
  a_multi_found: assert property (res_valid && res_multi |-> res_found)
    else $error("multi without found");
  a_lines_found: assert property (
      res_valid && !res_half && res_vec != 16'h0000 |-> res_found)
    else $error("match line without found");
endmodule // cams_sva

`default_nettype wire

// file: tb/tb_cams_search_block.sv
// Purpose: Self-checking bench of host end and search memory joined
// Assumes: 10 MHz clock, reset held 8 cycles
// Notes:   Reference model mirrors memory contents and care masks
`timescale 1ns/1ps
`default_nettype none

module tb_cams_search_block;
  // ==========================================================
  // Preload image
  // ==========================================================
  function automatic logic [1023:0] mk_init();
    logic [1023:0] r;
    for (int i = 0; i < 32; i++) r[i*32 +: 32] = 32'h5a5a_0000 | 32'(i);
    return r;
  endfunction
  localparam logic [1023:0] INIT_D = mk_init();

  logic i_clock, i_rst_b, wr_go, srch_go, srch_mode, wr_busy, srch_busy, done, found, multi;
  logic [4:0] wr_addr, maddr;
  logic [31:0] wr_data, wr_dc, srch_key, mvec, seed, d, dc;
  logic [31:0] mdat [32];
  logic [31:0] mcare [32];
  int err_total, samples_checked;

  // ==========================================================
  // Design under test
  // ==========================================================
  cams_if link ();
  cams_dev #(.INIT_DATA(INIT_D)) cams_dev_inst (.i_clock(i_clock), .i_rst_b(i_rst_b), .bus(link));
  cams_host cams_host_inst (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_wr_go(wr_go),
    .i_wr_addr(wr_addr), .i_wr_data(wr_data), .i_wr_dont_care(wr_dc), .o_wr_busy(wr_busy),
    .i_srch_go(srch_go), .i_srch_mode(srch_mode), .i_srch_key(srch_key),
    .o_srch_busy(srch_busy), .o_done(done), .o_found(found), .o_multi(multi),
    .o_match_addr(maddr), .o_match_vec(mvec), .bus(link));
  cams_sva cams_sva_inst (.i_clock(i_clock), .i_rst_b(i_rst_b), .wr_valid(link.wr_valid),
    .wr_ready(link.wr_ready), .wr_dont_care(link.wr_dont_care), .srch_valid(link.srch_valid),
    .srch_ready(link.srch_ready), .srch_mode(link.srch_mode), .res_valid(link.res_valid),
    .res_half(link.res_half), .res_found(link.res_found), .res_multi(link.res_multi),
    .res_addr(link.res_addr), .res_vec(link.res_vec));

  // Clock generation
  always #50 i_clock = ~i_clock;

  // ==========================================================
  // Helpers
  // ==========================================================
  function logic [31:0] next_rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Expected match lines for a key, from the model contents
  function automatic logic [31:0] exp_hits(input logic [31:0] k);
    logic [31:0] v;
    v = 32'h0;
    for (int i = 0; i < 32; i++) begin
      v[i] = (((mdat[i] ^ k) & mcare[i]) == 32'h0);
    end
    return v;
  endfunction

  // Expected encoded address: lowest matching word, zero if none
  function automatic logic [31:0] exp_addr(input logic [31:0] v);
    logic [31:0] a;
    a = 32'h0;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        a = 32'(i);
      end
    end
    return a;
  endfunction

  // Write one word, then wait for the link to go idle
  task automatic do_write(input logic [4:0] a, input logic [31:0] v, input logic [31:0] m);
    int n;
    n = 0;
    @(posedge i_clock);
    wr_go <= 1'b1; wr_addr <= a; wr_data <= v; wr_dc <= m;
    @(posedge i_clock);
    wr_go <= 1'b0;
    do begin @(posedge i_clock); #1; n++; end while (wr_busy && n < 20);
    if (wr_busy) check(32'h0, 32'h1);
    mdat[a] = v;
    mcare[a] = ~m;
  endtask

  // Search one key and compare against the model
  task automatic do_search(input logic m, input logic [31:0] k);
    logic [31:0] v;
    int n;
    v = exp_hits(k);
    n = 0;
    @(posedge i_clock);
    srch_go <= 1'b1;
    srch_mode <= m;
    srch_key <= k;
    @(posedge i_clock);
    srch_go <= 1'b0;
    #1;
    check(32'h1, {31'h0, srch_busy});
    do begin @(posedge i_clock); #1; n++; end while (done !== 1'b1 && n < 20);
    check(32'h1, {31'h0, done});
    check(32'h0, {31'h0, srch_busy});
    if (m == cams_pkg::MODE_UNENCODED) check(v, mvec);
    else check(32'h0, {16'h0, mvec[15:0]});
    check({31'h0, v != 32'h0}, {31'h0, found});
    check({31'h0, $countones(v) > 1}, {31'h0, multi});
    check(exp_addr(v), {27'h0, maddr});
  endtask

  // Watchdog against a hung handshake
  initial begin
    #(5000 * 100);
    err_total++;
    finish_test();
  end

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    i_clock = 1'b0; i_rst_b = 1'b0; seed = 32'h0001_4b77; err_total = 0; samples_checked = 0;
    wr_go <= 1'b0; wr_addr <= 5'h00; wr_data <= 32'h0; wr_dc <= 32'h0;
    srch_go <= 1'b0; srch_mode <= 1'b0; srch_key <= 32'h0;
    for (int i = 0; i < 32; i++) begin mdat[i] = INIT_D[i*32 +: 32]; mcare[i] = 32'hffff_ffff; end
    repeat (8) @(posedge i_clock);
    i_rst_b <= 1'b1;
    // Preloaded words, both halves, and a miss
    do_search(cams_pkg::MODE_ENCODED, 32'h5a5a_0007);
    do_search(cams_pkg::MODE_UNENCODED, 32'h5a5a_001f);
    do_search(cams_pkg::MODE_UNENCODED, 32'h5a5a_0003);
    do_search(cams_pkg::MODE_ENCODED, 32'h0000_0000);
    // Duplicate entries in both halves of the array, at words 2 and 30
    do_write(5'h02, 32'hbeef_0042, 32'h0);
    do_write(5'h1e, 32'hbeef_0042, 32'h0);
    do_search(cams_pkg::MODE_ENCODED, 32'hbeef_0042);
    do_search(cams_pkg::MODE_UNENCODED, 32'hbeef_0042);
    // Masked word matched through its don't-care bits
    do_write(5'h09, 32'h1234_5678, 32'h0000_ffff);
    do_search(cams_pkg::MODE_ENCODED, 32'h1234_abcd);
    do_search(cams_pkg::MODE_UNENCODED, 32'h1234_0000);
    // Random writes, each followed by a search for the stored word
    for (int j = 0; j < 40; j++) begin
      d = next_rnd();
      dc = d[5] ? (next_rnd() & 32'h0f0f_0000) : 32'h0;
      do_write(d[4:0], next_rnd(), dc);
      do_search(d[6], mdat[d[4:0]] ^ (dc & next_rnd()));
      do_search(d[7], next_rnd());
    end
    finish_test();
  end
endmodule // tb_cams_search_block

`default_nettype wire
